// >>> hdl/sopc_cfg_decode.sv
`timescale 1ns/1ps
module sopc_cfg_decode (
  sopc_cfg_if.dst cfg,
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic synth_clock,
  output logic host_clock_pin_oe,
  output logic host_clock_pin_out,
  output logic pci_clk_en,
  output logic dot_clock_internal,
  output logic graphics_clock_internal,
  output logic second_serial_port_internal,
  output logic first_serial_port_internal,
  output logic panel_low_bits_en,
  output logic parallel_internal,
  output logic kbd_mouse_internal,
  output logic localbus_selected,
  output logic pccard_selected
);
  logic [7:0] c;
  logic [7:0] f;

  assign c = cfg.clock_select_straps;
  assign f = cfg.interface_select_straps;

  assign dot_clock_internal = c[sopc_pkg::CLK_DOT_SRC_BIT];
  assign graphics_clock_internal = c[sopc_pkg::CLK_GFX_SRC_BIT];
  assign host_clock_pin_oe = c[sopc_pkg::CLK_HOST_DIR_BIT];
  assign host_clock_pin_out = c[sopc_pkg::CLK_HOST_DIR_BIT] & synth_clock;
  assign second_serial_port_internal = f[sopc_pkg::IF_SER2_BIT];
  assign first_serial_port_internal = f[sopc_pkg::IF_SER1_BIT];
  assign panel_low_bits_en = !f[sopc_pkg::IF_SER1_BIT];
  assign parallel_internal = f[sopc_pkg::IF_PAR_BIT];
  assign kbd_mouse_internal = f[sopc_pkg::IF_KBD_BIT];
  assign localbus_selected = f[sopc_pkg::IF_ISA_LB_BIT];
  assign pccard_selected = f[sopc_pkg::IF_PCI_PCCARD_BIT];

  sopc_pci_clkdiv u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .div_by_two(c[sopc_pkg::CLK_PCI_DIV_BIT]),
    .pci_clk_en(pci_clk_en)
  );

  property p_panel;
    @(posedge mclk) disable iff (!rst_n)
    panel_low_bits_en != first_serial_port_internal;
  endproperty
  a_panel: assert property (p_panel) else $error("panel outputs not tied to serial select");
endmodule

// >>> hdl/sopc_cfg_if.sv
`timescale 1ns/1ps
interface sopc_cfg_if;
  logic [7:0] clock_select_straps;
  logic [7:0] interface_select_straps;
  modport src (output clock_select_straps, output interface_select_straps);
  modport dst (input clock_select_straps, input interface_select_straps);
endinterface

// >>> hdl/sopc_pci_clkdiv.sv
`timescale 1ns/1ps
module sopc_pci_clkdiv (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic div_by_two,
  output logic pci_clk_en
);
  logic [1:0] count;
  logic [1:0] next_count;
  logic [1:0] last;

  // Enable pulse once every two or three host cycles
  always_comb
  begin
    last = div_by_two ? sopc_pkg::PCI_DIV_TWO_LAST : sopc_pkg::PCI_DIV_THREE_LAST;
    next_count = (count >= last) ? 2'h0 : count + 2'h1;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      count <= 2'h0;
    else
      count <= next_count;
  end

  assign pci_clk_en = (count == 2'h0);

  property p_div_three;
    @(posedge mclk) disable iff (!rst_n)
    (!div_by_two && pci_clk_en) ##1 !div_by_two [*2] |-> !pci_clk_en ##1 pci_clk_en;
  endproperty
  a_div_three: assert property (p_div_three) else $error("pci enable not every third cycle");

  property p_div_two;
    @(posedge mclk) disable iff (!rst_n)
    (div_by_two && pci_clk_en) ##1 div_by_two [*2] |-> pci_clk_en;
  endproperty
  a_div_two: assert property (p_div_two) else $error("pci enable not every second cycle");
endmodule

// >>> hdl/sopc_pkg.sv
package sopc_pkg;
  // ----------------------------------------
  // Index/data port pair
  // ----------------------------------------
  localparam logic [7:0] INDEX_PORT = 8'h22;
  localparam logic [7:0] DATA_PORT = 8'h23;
  localparam logic [7:0] IDX_IFACE = 8'h3c;
  localparam logic [7:0] IDX_CLOCK = 8'h4c;

  // ----------------------------------------
  // Clock strap register fields
  // ----------------------------------------
  localparam int CLK_PCI_DIV_BIT = 1;
  localparam int CLK_HOST_DIR_BIT = 2;
  localparam int CLK_GFX_SRC_BIT = 3;
  localparam int CLK_DOT_SRC_BIT = 4;
  localparam int CLK_SPARE_BIT = 5;
  localparam logic [7:0] CLK_WRITE_MASK = 8'h10;

  // ----------------------------------------
  // Interface strap register fields
  // ----------------------------------------
  localparam int IF_PCI_PCCARD_BIT = 0;
  localparam int IF_ISA_LB_BIT = 1;
  localparam int IF_KBD_BIT = 2;
  localparam int IF_PAR_BIT = 3;
  localparam int IF_SER1_BIT = 4;
  localparam int IF_SER2_BIT = 5;

  // ----------------------------------------
  // Reset values and PCI clock divisor
  // ----------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] PCI_DIV_THREE_LAST = 2'h2;
  localparam logic [1:0] PCI_DIV_TWO_LAST = 2'h1;

  typedef enum logic [1:0] {
    SOPC_CAP_RESET = 2'b00,
    SOPC_CAP_TAKE = 2'b01,
    SOPC_CAP_HELD = 2'b11
  } sopc_cap_state_t;
endpackage

// >>> hdl/sopc_strap_regs.sv
`timescale 1ns/1ps
module sopc_strap_regs (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [63:0] mem_data_in,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic host_clock_pin_oe,
  output logic host_clock_pin_out,
  input wire logic synth_clock,
  output logic pci_clk_en,
  output logic dot_clock_internal,
  output logic graphics_clock_internal,
  output logic second_serial_port_internal,
  output logic first_serial_port_internal,
  output logic panel_low_bits_en,
  output logic parallel_internal,
  output logic kbd_mouse_internal,
  output logic localbus_selected,
  output logic pccard_selected
);
  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // Strap capture and index/data port
  // ----------------------------------------
  sopc_cfg_if cfg ();
  sopc_pkg::sopc_cap_state_t state;
  sopc_pkg::sopc_cap_state_t next_state;
  logic [7:0] index;
  logic [7:0] next_index;
  logic [7:0] clk_reg;
  logic [7:0] next_clk_reg;
  logic [7:0] if_reg;
  logic [7:0] next_if_reg;
  logic [7:0] next_rdata;
  logic [7:0] sampled_clk;

  // Straps sit on the memory bus only while reset holds the bus idle
  assign sampled_clk = {2'b00, mem_data_in[23], mem_data_in[20:16]};

  always_comb
  begin
    next_state = state;
    next_index = index;
    next_clk_reg = clk_reg;
    next_if_reg = if_reg;
    next_rdata = io_rdata;
    case (state)
      sopc_pkg::SOPC_CAP_RESET:
        next_state = sopc_pkg::SOPC_CAP_TAKE;
      sopc_pkg::SOPC_CAP_TAKE:
      begin
        next_clk_reg = sampled_clk;
        next_if_reg = mem_data_in[47:40];
        next_state = sopc_pkg::SOPC_CAP_HELD;
      end
      sopc_pkg::SOPC_CAP_HELD:
      begin
        if (io_wr && io_addr == sopc_pkg::INDEX_PORT)
          next_index = io_wdata;
        if (io_wr && io_addr == sopc_pkg::DATA_PORT && index == sopc_pkg::IDX_CLOCK)
          next_clk_reg = (clk_reg & ~sopc_pkg::CLK_WRITE_MASK)
                       | (io_wdata & sopc_pkg::CLK_WRITE_MASK);
        if (io_rd)
        begin
          if (io_addr == sopc_pkg::INDEX_PORT)
            next_rdata = index;
          else if (io_addr == sopc_pkg::DATA_PORT && index == sopc_pkg::IDX_CLOCK)
            next_rdata = clk_reg;
          else if (io_addr == sopc_pkg::DATA_PORT && index == sopc_pkg::IDX_IFACE)
            next_rdata = if_reg;
          else
            next_rdata = sopc_pkg::REG_RESET;
        end
      end
      default:
        next_state = sopc_pkg::SOPC_CAP_RESET;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= sopc_pkg::SOPC_CAP_RESET;
      index <= sopc_pkg::REG_RESET;
      clk_reg <= sopc_pkg::REG_RESET;
      if_reg <= sopc_pkg::REG_RESET;
      io_rdata <= sopc_pkg::REG_RESET;
    end
    else
    begin
      state <= next_state;
      index <= next_index;
      clk_reg <= next_clk_reg;
      if_reg <= next_if_reg;
      io_rdata <= next_rdata;
    end
  end

  assign cfg.clock_select_straps = clk_reg;
  assign cfg.interface_select_straps = if_reg;

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  sopc_cfg_decode u_decode (
    .cfg(cfg.dst),
    .mclk(mclk),
    .rst_n(rst_n),
    .synth_clock(synth_clock),
    .host_clock_pin_oe(host_clock_pin_oe),
    .host_clock_pin_out(host_clock_pin_out),
    .pci_clk_en(pci_clk_en),
    .dot_clock_internal(dot_clock_internal),
    .graphics_clock_internal(graphics_clock_internal),
    .second_serial_port_internal(second_serial_port_internal),
    .first_serial_port_internal(first_serial_port_internal),
    .panel_low_bits_en(panel_low_bits_en),
    .parallel_internal(parallel_internal),
    .kbd_mouse_internal(kbd_mouse_internal),
    .localbus_selected(localbus_selected),
    .pccard_selected(pccard_selected)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_capture;
    state == sopc_pkg::SOPC_CAP_TAKE;
  endsequence

  sequence s_start;
    state == sopc_pkg::SOPC_CAP_RESET;
  endsequence

  sequence s_held;
    state == sopc_pkg::SOPC_CAP_HELD;
  endsequence

  property p_capture_clock;
    @(posedge mclk) disable iff (!rst_n)
    s_capture |=> clk_reg == $past(sampled_clk);
  endproperty
  a_capture_clock: assert property (p_capture_clock) else $error("clock straps not captured");

  property p_capture_iface;
    @(posedge mclk) disable iff (!rst_n)
    s_capture |=> if_reg == $past(mem_data_in[47:40]);
  endproperty
  a_capture_iface: assert property (p_capture_iface) else $error("interface straps not captured");

  property p_held;
    @(posedge mclk) disable iff (!rst_n)
    state == sopc_pkg::SOPC_CAP_HELD |=> $stable(if_reg) && state == sopc_pkg::SOPC_CAP_HELD;
  endproperty
  a_held: assert property (p_held) else $error("straps changed after capture");

  property p_ro_bits;
    @(posedge mclk) disable iff (!rst_n)
    state == sopc_pkg::SOPC_CAP_HELD |=> (clk_reg & ~sopc_pkg::CLK_WRITE_MASK)
                                      == ($past(clk_reg) & ~sopc_pkg::CLK_WRITE_MASK);
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("read-only clock bit changed");

  property p_dot_write;
    @(posedge mclk) disable iff (!rst_n)
    (state == sopc_pkg::SOPC_CAP_HELD && io_wr && io_addr == sopc_pkg::DATA_PORT
      && index == sopc_pkg::IDX_CLOCK)
    |=> clk_reg[4] == $past(io_wdata[4]) && dot_clock_internal == $past(io_wdata[4]);
  endproperty
  a_dot_write: assert property (p_dot_write) else $error("dot clock write lost");

  property p_read_clock;
    @(posedge mclk) disable iff (!rst_n)
    (state == sopc_pkg::SOPC_CAP_HELD && io_rd && io_addr == sopc_pkg::DATA_PORT
      && index == sopc_pkg::IDX_CLOCK && !io_wr) |=> io_rdata == $past(clk_reg);
  endproperty
  a_read_clock: assert property (p_read_clock) else $error("clock register read wrong");

  // ----------------------------------------
  // Port protocol and capture checks
  // ----------------------------------------
  // Software may poll the ports freely, so reads must never disturb state
  property p_index_write;
    @(posedge mclk) disable iff (!rst_n)
    (state == sopc_pkg::SOPC_CAP_HELD && io_wr && io_addr == sopc_pkg::INDEX_PORT)
      |=> index == $past(io_wdata);
  endproperty
  a_index_write: assert property (p_index_write) else $error("index write lost");

  property p_index_keep;
    @(posedge mclk) disable iff (!rst_n)
    !(state == sopc_pkg::SOPC_CAP_HELD && io_wr && io_addr == sopc_pkg::INDEX_PORT)
      |=> $stable(index);
  endproperty
  a_index_keep: assert property (p_index_keep) else $error("index moved without a write");

  property p_read_index;
    @(posedge mclk) disable iff (!rst_n)
    (state == sopc_pkg::SOPC_CAP_HELD && io_rd && io_addr == sopc_pkg::INDEX_PORT)
      |=> io_rdata == $past(index);
  endproperty
  a_read_index: assert property (p_read_index) else $error("index read wrong");

  property p_read_iface;
    @(posedge mclk) disable iff (!rst_n)
    (state == sopc_pkg::SOPC_CAP_HELD && io_rd && io_addr == sopc_pkg::DATA_PORT && index == sopc_pkg::IDX_IFACE)
      |=> io_rdata == $past(if_reg);
  endproperty
  a_read_iface: assert property (p_read_iface) else $error("interface register read wrong");

  property p_read_unmapped;
    @(posedge mclk) disable iff (!rst_n)
    (state == sopc_pkg::SOPC_CAP_HELD && io_rd && io_addr == sopc_pkg::DATA_PORT
      && index != sopc_pkg::IDX_CLOCK && index != sopc_pkg::IDX_IFACE)
      |=> io_rdata == sopc_pkg::REG_RESET;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped index read not zero");

  property p_rdata_stands;
    @(posedge mclk) disable iff (!rst_n)
    !(state == sopc_pkg::SOPC_CAP_HELD && io_rd)
      |=> $stable(io_rdata);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved without a read");

  property p_clock_keep;
    @(posedge mclk) disable iff (!rst_n)
    (state == sopc_pkg::SOPC_CAP_HELD && !(io_wr && io_addr == sopc_pkg::DATA_PORT && index == sopc_pkg::IDX_CLOCK))
      |=> $stable(clk_reg);
  endproperty
  a_clock_keep: assert property (p_clock_keep) else $error("clock register moved without a write");

  // Neither strap register nor the index may move before the straps are taken
  property p_refused_early;
    @(posedge mclk) disable iff (!rst_n)
    s_start |=> $stable(clk_reg) && $stable(if_reg) && $stable(index);
  endproperty
  a_refused_early: assert property (p_refused_early) else $error("state moved before capture");

  property p_capture_order;
    @(posedge mclk) disable iff (!rst_n)
    s_start |=> s_capture ##1 s_held;
  endproperty
  a_capture_order: assert property (p_capture_order) else $error("capture steps out of order");

  property p_capture_clock_outs;
    @(posedge mclk) disable iff (!rst_n)
    s_capture |=> dot_clock_internal == $past(sampled_clk[sopc_pkg::CLK_DOT_SRC_BIT])
      && graphics_clock_internal == $past(sampled_clk[sopc_pkg::CLK_GFX_SRC_BIT])
      && host_clock_pin_oe == $past(sampled_clk[sopc_pkg::CLK_HOST_DIR_BIT]);
  endproperty
  a_capture_clock_outs: assert property (p_capture_clock_outs) else $error("clock selects not from straps");

  property p_capture_iface_outs;
    @(posedge mclk) disable iff (!rst_n)
    s_capture |=> {second_serial_port_internal, first_serial_port_internal, parallel_internal,
      kbd_mouse_internal, localbus_selected, pccard_selected} == $past(mem_data_in[45:40]);
  endproperty
  a_capture_iface_outs: assert property (p_capture_iface_outs) else $error("interface selects not from straps");

  property p_capture_panel;
    @(posedge mclk) disable iff (!rst_n)
    s_capture |=> panel_low_bits_en == !$past(mem_data_in[44]);
  endproperty
  a_capture_panel: assert property (p_capture_panel) else $error("panel outputs not from serial strap");
endmodule

// >>> tb/sopc_strap_board.sv
`timescale 1ns/1ps
// ----------------------------------------
// Board strap resistors on the memory data pins
// ----------------------------------------
module sopc_strap_board (
  input wire logic mclk,
  input wire logic hold,
  input wire logic [63:0] straps,
  output logic [63:0] mem_data
);
  logic [63:0] busy;
  // Once reset is over the pins carry memory traffic, so show a toggling pattern
  always_ff @(posedge mclk)
  begin
    busy <= hold ? ~straps : ~busy;
  end
  assign mem_data = hold ? straps : busy;
endmodule

// >>> tb/strap_option_capture_regs_tb.sv
`timescale 1ns/1ps
module strap_option_capture_regs_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hold = 1'b1;
  logic [63:0] straps = 64'h0;
  logic [63:0] mem_data;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic synth_clock = 1'b0;
  logic oe, hout, pci_en, dot, gfx, ser2, ser1, panel, par, kbd, lb, pcc;
  logic [31:0] seed = 32'hf730_5680;
  logic [7:0] rd, exp_clk, exp_if, wd;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n, gap;

  always #2.5 mclk = ~mclk;

  sopc_strap_board board (.mclk(mclk), .hold(hold), .straps(straps), .mem_data(mem_data));

  sopc_strap_regs dut (.mclk(mclk), .resetn(resetn), .mem_data_in(mem_data), .io_wr(io_wr),
    .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .host_clock_pin_oe(oe), .host_clock_pin_out(hout), .synth_clock(synth_clock),
    .pci_clk_en(pci_en), .dot_clock_internal(dot), .graphics_clock_internal(gfx),
    .second_serial_port_internal(ser2), .first_serial_port_internal(ser1),
    .panel_low_bits_en(panel), .parallel_internal(par), .kbd_mouse_internal(kbd),
    .localbus_selected(lb), .pccard_selected(pcc));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      errors++;
    end
  endtask

  task close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task io_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = d;
    @(negedge mclk);
    io_wr = 1'b0;
  endtask

  // Data is registered, so it is taken one cycle after the strobe
  task read_reg(input logic [7:0] idx, output logic [7:0] d);
    io_write(sopc_pkg::INDEX_PORT, idx);
    @(negedge mclk);
    io_rd = 1'b1;
    io_addr = sopc_pkg::DATA_PORT;
    @(negedge mclk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask

  task check_outputs;
    @(negedge mclk);
    seed = lfsr(seed);
    synth_clock = seed[3];
    #1;
    chk("clock_outs", {3'b000, dot, gfx, oe, 2'b00}, exp_clk & 8'h1c);
    chk("host_pin", {7'h00, hout}, {7'h00, exp_clk[2] & seed[3]});
    chk("iface_outs", {2'b00, ser2, ser1, par, kbd, lb, pcc}, exp_if & 8'h3f);
    chk("panel", {7'h00, panel}, {7'h00, ~exp_if[4]});
  endtask

  // Period of the PCI clock enable in host clock cycles
  task pci_gap;
    for (gap = 0; gap < 8 && pci_en !== 1'b1; gap++)
      @(negedge mclk);
    @(negedge mclk);
    gap = 1;
    while (gap < 8 && pci_en !== 1'b1)
    begin
      @(negedge mclk);
      gap++;
    end
    chk("pci_gap", gap[7:0], exp_clk[1] ? 8'h02 : 8'h03);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      close_out;
    end
  end

  initial
  begin
    for (n = 0; n < 6; n++)
    begin
      @(negedge mclk);
      seed = lfsr(seed);
      straps[31:0] = seed;
      seed = lfsr(seed);
      straps[63:32] = seed;
      if (n == 0)
        straps = 64'h0;
      if (n == 1)
        straps = ~64'h0;
      resetn = 1'b0;
      hold = 1'b1;
      repeat (3) @(negedge mclk);
      resetn = 1'b1;
      repeat (8) @(negedge mclk);
      hold = 1'b0;
      exp_clk = {2'b00, straps[23], straps[20:16]};
      exp_if = straps[47:40];
      read_reg(sopc_pkg::IDX_CLOCK, rd);
      chk("clock_reg", rd, exp_clk);
      read_reg(sopc_pkg::IDX_IFACE, rd);
      chk("iface_reg", rd, exp_if);
      check_outputs;
      pci_gap;
      seed = lfsr(seed);
      wd = seed[7:0];
      io_write(sopc_pkg::INDEX_PORT, sopc_pkg::IDX_CLOCK);
      io_write(sopc_pkg::DATA_PORT, wd);
      exp_clk[4] = wd[4];
      read_reg(sopc_pkg::IDX_CLOCK, rd);
      chk("clock_wr", rd, exp_clk);
      io_write(sopc_pkg::INDEX_PORT, sopc_pkg::IDX_IFACE);
      io_write(sopc_pkg::DATA_PORT, ~exp_if);
      read_reg(sopc_pkg::IDX_IFACE, rd);
      chk("iface_wr", rd, exp_if);
      read_reg(8'h4d, rd);
      chk("unmapped", rd, 8'h00);
      check_outputs;
      $display("test %0d done", n);
    end
    close_out;
  end
endmodule
